// *** ibea_pkg.sv ***
// ibea_pkg: constants and types for the two-wire bus error and
// arbitration core.
// assumes a single 100 MHz system clock and an open-drain bus.
package ibea_pkg;

    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int CLK_MHZ = 100;          // system clock rate
    localparam int T_HALF_NS = 5000;       // half of a 100 kHz bus period
    // least time, so round up to whole cycles
    localparam int HALF_CYC = (T_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam logic [9:0] HALF_CNT = 10'(HALF_CYC - 1);

    // -----------------------------------------------------------------
    // bit positions inside a frame
    // -----------------------------------------------------------------
    localparam logic [3:0] BIT_ADDR = 4'h8;  // rises seen at byte end
    localparam logic [3:0] BIT_ACK = 4'h9;   // rise of the ack bit
    localparam logic [3:0] BIT_OK = 4'h1;    // start/stop legal up to here

    // -----------------------------------------------------------------
    // status codes
    // -----------------------------------------------------------------
    localparam logic [7:0] ST_NONE = 8'hF8;     // nothing to report
    localparam logic [7:0] ST_BUS_ERR = 8'h00;  // misplaced start/stop
    localparam logic [7:0] ST_M_DONE = 8'h28;   // master byte sent
    localparam logic [7:0] ST_ARB_DATA = 8'h38; // lost, not addressed
    localparam logic [7:0] ST_SR = 8'h60;       // own address, write
    localparam logic [7:0] ST_ARB_SR = 8'h68;   // lost, then written to
    localparam logic [7:0] ST_ST = 8'hA8;       // own address, read
    localparam logic [7:0] ST_ARB_ST = 8'hB0;   // lost, then read from

    // -----------------------------------------------------------------
    // controller states
    // -----------------------------------------------------------------
    typedef enum logic [8:0] {
        S_IDLE   = 9'b0_0000_0001,  // not addressed slave, bus watch
        S_START  = 9'b0_0000_0010,  // sda low with scl high
        S_LOW    = 9'b0_0000_0100,  // scl low, data set up
        S_HIGH   = 9'b0_0000_1000,  // scl released, data sampled
        S_HOLD   = 9'b0_0001_0000,  // byte done, scl held low
        S_RSTART = 9'b0_0010_0000,  // repeated start preparation
        S_STOP   = 9'b0_0100_0000,  // stop generation
        S_ERR    = 9'b0_1000_0000,  // bus error, waiting for recovery
        S_SLV    = 9'b1_0000_0000   // addressed slave
    } ibea_state_t;

    // whole state of the core
    typedef struct packed {
        ibea_state_t state;
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        logic busy;
        logic [3:0] bcnt;
        logic first;
        logic [7:0] rx;
        logic [9:0] tmr;
        logic ph;
        logic [3:0] mbit;
        logic addr_b;
        logic arb_addr;
        logic [7:0] tx;
        logic flag;
        logic [7:0] status;
        logic start;
        logic stop;
        logic ack_en;
        logic scl_oe_n;
        logic sda_oe_n;
    } ibea_st_t;

    localparam ibea_st_t ST_RESET = '{state: S_IDLE, scl_m: 1'b1,
        scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
        status: ST_NONE, scl_oe_n: 1'b1, sda_oe_n: 1'b1, default: '0};

endpackage : ibea_pkg

// *** ibea_core.sv ***
// ibea_core: two-wire bus controller that watches for misplaced start
// and stop conditions, recovers from them, and arbitrates as master.
// assumes open-drain pins resolved outside; software side is plain ports.
//
// Overview of operation
// - status reads F8 while flag clear
// - bus error reports status 00
// - start/stop inside a byte is error, except in S_IDLE and S_ERR
// - bus error sets the complete flag
// - recovery: unaddressed slave, stop bit self-clears
// - recovery releases lines, sends no stop
// - repeated start keeps bus, allows turnaround
// - identical masters see no contention
// - sending one while bus low loses
// - data loss: unaddressed or restart later
// - address loss: check own address first
module ibea_core (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // software control write
    input wire logic i_ctl_wr,
    input wire logic i_ctl_start,
    input wire logic i_ctl_stop,
    input wire logic i_ctl_ack_en,
    input wire logic i_ctl_int_clr,
    input wire logic [7:0] i_tx_byte,
    input wire logic [6:0] i_own_addr,
    // software status
    output logic o_op_complete,
    output logic [7:0] o_status,
    output logic o_ctl_start,
    output logic o_ctl_stop,
    output logic o_ctl_ack_en,
    output logic [7:0] o_rx_byte,
    output logic o_bus_busy,
    // bus pins
    input wire logic i_scl,
    output logic o_scl_o,
    output logic o_scl_oe_n,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe_n
);
    import ibea_pkg::*;

    // -----------------------------------------------------------------
    // state and helpers
    // -----------------------------------------------------------------
    ibea_st_t q;        // registered state
    ibea_st_t d;        // next state
    logic start_det;    // start seen on the bus
    logic stop_det;     // stop seen on the bus
    logic scl_rise;     // clock rising edge
    logic scl_fall;     // clock falling edge
    logic tdone;        // half period elapsed
    logic act;          // flag cleared by software
    logic txbit;        // bit this master is sending
    logic lost;         // arbitration lost at this sample
    logic berr;         // misplaced start or stop
    logic adr_end;      // address byte complete on the bus
    logic match;        // address byte names us

    // edges read only the second and third stages, never the first
    assign start_det = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    assign stop_det = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
    assign scl_rise = q.scl_s & ~q.scl_p;
    assign scl_fall = ~q.scl_s & q.scl_p;
    assign tdone = (q.tmr == HALF_CNT);
    assign act = i_ctl_wr & i_ctl_int_clr & q.flag;
    assign txbit = (q.mbit < BIT_ADDR) ? q.tx[3'(4'd7 - q.mbit)] : 1'b1;
    // only a one meeting a zero loses; equal bits go on unnoticed
    assign lost = (q.state == S_HIGH) & tdone & q.scl_s & txbit
                & ~q.sda_s & (q.mbit < BIT_ADDR);
    // legal only until the second bit of a byte has been clocked
    assign berr = (start_det | stop_det) & q.busy & (q.bcnt > BIT_OK)
                & (q.state != S_IDLE) & (q.state != S_ERR);
    assign adr_end = scl_fall & q.first & (q.bcnt == BIT_ADDR);
    assign match = (q.rx[7:1] == i_own_addr) & q.ack_en;

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        d = q;
        // two-stage pin synchronisers, then one stage for edges
        d.scl_m = i_scl;
        d.scl_s = q.scl_m;
        d.scl_p = q.scl_s;
        d.sda_m = i_sda;
        d.sda_s = q.sda_m;
        d.sda_p = q.sda_s;
        d.tmr = q.tmr + 10'd1;
        // software write; data byte rides with every write
        if (i_ctl_wr) begin
            d.start = i_ctl_start;
            d.stop = i_ctl_stop;
            d.ack_en = i_ctl_ack_en;
            d.tx = i_tx_byte;
        end
        // clearing the flag brings back the idle code; any set below wins
        if (act) begin
            d.flag = 1'b0;
            d.status = ST_NONE;
        end
        // bus monitor: busy window and position inside the byte
        if (start_det) begin
            d.busy = 1'b1;
            d.bcnt = '0;
            d.first = 1'b1;
        end else if (stop_det) begin
            d.busy = 1'b0;
            d.bcnt = '0;
        end else if (scl_rise && q.busy) begin
            // a data byte's first rise still finds the count at the ack
            // position, so that rise has to shift as well
            if (q.bcnt < BIT_ADDR || q.bcnt == BIT_ACK) begin
                d.rx = {q.rx[6:0], q.sda_s};
            end
            if (q.bcnt == BIT_ACK) begin
                d.bcnt = BIT_OK;
                d.first = 1'b0;
            end else begin
                d.bcnt = q.bcnt + 4'd1;
            end
        end
        unique case (q.state)
            S_IDLE: begin
                // address check also finishes an address arbitration loss
                if (adr_end && match) begin
                    d.state = S_SLV;
                    d.sda_oe_n = 1'b0;
                    d.flag = 1'b1;
                    d.arb_addr = 1'b0;
                    if (q.rx[0]) begin
                        d.status = q.arb_addr ? ST_ARB_ST : ST_ST;
                    end else begin
                        d.status = q.arb_addr ? ST_ARB_SR : ST_SR;
                    end
                end else if (adr_end && q.arb_addr) begin
                    // not for us: same as a loss in the data bits
                    d.flag = 1'b1;
                    d.status = ST_ARB_DATA;
                    d.arb_addr = 1'b0;
                end else if (q.start && !q.busy && !q.flag) begin
                    // a pending start waits here for a free bus
                    d.state = S_START;
                    d.sda_oe_n = 1'b0;
                    d.addr_b = 1'b1;
                    d.mbit = '0;
                end
            end
            S_START: begin
                if (tdone) begin
                    d.state = S_LOW;
                    d.scl_oe_n = 1'b0;
                end
            end
            S_LOW: begin
                // data changes one cycle after scl is pulled low
                d.sda_oe_n = txbit;
                if (tdone) begin
                    d.state = S_HIGH;
                    d.scl_oe_n = 1'b1;
                end
            end
            S_HIGH: begin
                // a slave stretching scl holds the half period back
                if (!q.scl_s) begin
                    d.tmr = '0;
                end
                if (lost) begin
                    d.state = S_IDLE;
                    d.sda_oe_n = 1'b1;
                    if (q.addr_b) begin
                        d.arb_addr = 1'b1;
                    end else begin
                        d.flag = 1'b1;
                        d.status = ST_ARB_DATA;
                    end
                end else if (tdone && q.scl_s) begin
                    d.scl_oe_n = 1'b0;
                    if (q.mbit == BIT_ADDR) begin
                        d.state = S_HOLD;
                        d.sda_oe_n = 1'b1;
                        d.flag = 1'b1;
                        d.status = ST_M_DONE;
                    end else begin
                        d.state = S_LOW;
                        d.mbit = q.mbit + 4'd1;
                    end
                end
            end
            S_HOLD: begin
                // the write that clears the flag carries the next step;
                // stale bits from an earlier write must not steer it
                if (act && i_ctl_stop) begin
                    d.state = S_STOP;
                    d.sda_oe_n = 1'b0;
                    d.ph = 1'b0;
                end else if (act && i_ctl_start) begin
                    // bus stays ours: scl stays low until the restart
                    d.state = S_RSTART;
                    d.ph = 1'b0;
                end else if (act) begin
                    d.state = S_LOW;
                    d.mbit = '0;
                    d.addr_b = 1'b0;
                end
            end
            S_RSTART: begin
                if (tdone && !q.ph) begin
                    d.ph = 1'b1;
                    d.scl_oe_n = 1'b1;
                    d.tmr = '0;
                end else if (tdone && q.scl_s) begin
                    // new address byte may carry the other direction
                    d.state = S_START;
                    d.sda_oe_n = 1'b0;
                    d.addr_b = 1'b1;
                    d.mbit = '0;
                end
            end
            S_STOP: begin
                if (tdone && !q.ph) begin
                    d.ph = 1'b1;
                    d.scl_oe_n = 1'b1;
                    d.tmr = '0;
                end else if (tdone && q.scl_s) begin
                    d.state = S_IDLE;
                    d.sda_oe_n = 1'b1;
                    d.stop = 1'b0;
                end
            end
            S_ERR: begin
                // lines are already free; nothing goes out on the bus
                if (act && i_ctl_stop) begin
                    d.state = S_IDLE;
                    d.stop = 1'b0;
                end
            end
            S_SLV: begin
                // release the acknowledge after the ninth clock
                if (scl_fall && q.bcnt == BIT_ACK) begin
                    d.sda_oe_n = 1'b1;
                end
                if (start_det || stop_det) begin
                    d.state = S_IDLE;
                    d.sda_oe_n = 1'b1;
                end
            end
        endcase
        // a bus error overrides whatever the state was doing
        if (berr) begin
            d.state = S_ERR;
            d.flag = 1'b1;
            d.status = ST_BUS_ERR;
            d.scl_oe_n = 1'b1;
            d.sda_oe_n = 1'b1;
            d.arb_addr = 1'b0;
        end
        if (d.state != q.state) begin
            d.tmr = '0;
        end
    end

    // -----------------------------------------------------------------
    // state register
    // -----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= ST_RESET;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign o_op_complete = q.flag;
    assign o_status = q.status;
    assign o_ctl_start = q.start;
    assign o_ctl_stop = q.stop;
    assign o_ctl_ack_en = q.ack_en;
    assign o_rx_byte = q.rx;
    assign o_bus_busy = q.busy;
    assign o_scl_oe_n = q.scl_oe_n;
    assign o_sda_oe_n = q.sda_oe_n;
    // open drain: only ever pulls low
    assign o_scl_o = 1'b0;
    assign o_sda_o = 1'b0;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence seq_err_seen;
        berr;
    endsequence
    sequence seq_err_flagged;
        q.state == S_ERR && q.flag && q.status == ST_BUS_ERR;
    endsequence

    chk_idle_code: assert property (
        !q.flag |-> q.status == ST_NONE)
        else $error("status not idle code with flag clear");
    chk_err_report: assert property (
        seq_err_seen |=> seq_err_flagged)
        else $error("bus error not reported");
    chk_err_recover: assert property (
        q.state == S_ERR && act && i_ctl_stop |=> q.state == S_IDLE
        && !q.stop && q.ack_en == $past(i_ctl_ack_en))
        else $error("bus error recovery wrong");
    chk_err_release: assert property (
        q.state == S_ERR |-> q.scl_oe_n && q.sda_oe_n)
        else $error("lines driven during bus error");
    chk_rstart_keep: assert property (
        q.state == S_RSTART && !berr |=> q.state inside {S_RSTART, S_START}
        && q.busy)
        else $error("bus let go during repeated start");
    chk_arb_loss: assert property (
        lost && !berr |=> q.state == S_IDLE && q.sda_oe_n && q.scl_oe_n)
        else $error("arbitration loss not taken");
    chk_no_contend: assert property (
        q.state == S_HIGH && tdone && q.scl_s && txbit == q.sda_s && !berr
        |=> q.state inside {S_LOW, S_HOLD})
        else $error("contention seen on equal bits");
    chk_data_loss: assert property (
        lost && !q.addr_b && !berr |=> q.flag && q.status == ST_ARB_DATA)
        else $error("data loss not reported");
    chk_addr_loss: assert property (
        lost && q.addr_b && !berr |=> q.arb_addr && !q.flag)
        else $error("address loss must check own address");

endmodule : ibea_core

// *** ibea_bus_peer.sv ***
// ibea_bus_peer: behavioural second master on the two-wire bus.
// assumes open-drain wires resolved by the bench with pull-ups, and a
// device that owns the first clock low phase after its own start.
module ibea_bus_peer (
    // clock
    input wire logic i_clk,
    // resolved wire levels
    input wire logic i_scl,
    input wire logic i_sda,
    // pull requests, high = pull the line low
    output logic o_scl_pull,
    output logic o_sda_pull,
    // bits where the wire differed from what this master sent
    output logic [7:0] o_errs,
    // level seen in the ninth bit of the first byte
    output logic o_ack
);
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // bus actions
    // ---------------------------------------------------------------
    initial begin
        o_scl_pull = 1'b0;
        o_sda_pull = 1'b0;
        o_errs = 8'h00;
        o_ack = 1'b1;
    end

    // wait a number of clocks
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick

    // wait for a clock level, bounded so a stuck line cannot hang us
    task automatic until_lvl(input logic lvl);
        int t = 0;
        while (i_scl !== lvl && t < 4000) begin
            @(posedge i_clk);
            t = t + 1;
        end
    endtask : until_lvl

    // join the device's start and send nb bits, msb first, then stop
    task automatic shadow(input logic [17:0] pat, input int nb);
        int t = 0;
        o_errs <= 8'h00;
        o_ack <= 1'b1;
        while (!(i_scl === 1'b1 && i_sda === 1'b0) && t < 4000) begin
            @(posedge i_clk);
            t = t + 1;
        end
        tick(520);
        o_scl_pull <= 1'b1;
        for (int k = 0; k < nb; k++) begin
            tick(10);
            // data changes only while the clock is low
            o_sda_pull <= !pat[17-k];
            tick(500);
            o_scl_pull <= 1'b0;
            until_lvl(1'b1);
            // sample mid-high: the device ends its high half near 500
            // cycles and moves sda one cycle after pulling scl low
            tick(250);
            if (i_sda !== pat[17-k]) begin
                o_errs <= o_errs + 8'h01;
            end
            if (k == 8) begin
                o_ack <= i_sda;
            end
            tick(270);
            o_scl_pull <= 1'b1;
            until_lvl(1'b0);
        end
        tick(10);
        // stop: sda low under a low clock, clock up, then sda up
        o_sda_pull <= 1'b1;
        tick(500);
        o_scl_pull <= 1'b0;
        until_lvl(1'b1);
        tick(520);
        o_sda_pull <= 1'b0;
    endtask : shadow

    // pull sda low inside the high half of a chosen clock pulse
    task automatic glitch(input int rises);
        int n = 0;
        logic prev = 1'b1;
        for (int t = 0; t < 20000 && n < rises; t++) begin
            @(posedge i_clk);
            if (i_scl === 1'b1 && prev === 1'b0) begin
                n = n + 1;
            end
            prev = i_scl;
        end
        tick(100);
        // a start in mid-byte; its release later forms a stop
        o_sda_pull <= 1'b1;
        tick(200);
        o_sda_pull <= 1'b0;
    endtask : glitch

endmodule : ibea_bus_peer

// *** i2c_bus_error_arbitration_bench.sv ***
// bench for ibea_core: a second master shares the bus with the device.
// assumes pull-ups on both lines and software writes as plain strobes.
module i2c_bus_error_arbitration_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ibea_pkg::*;

    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    localparam int LIMIT = 95000; // cycles for the whole run
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ctl_wr = 1'b0;
    logic ctl_sta = 1'b0;
    logic ctl_sto = 1'b0;
    logic ctl_ack = 1'b0;
    logic ctl_clr = 1'b0;
    logic [7:0] tx = 8'h00;
    logic [6:0] own = 7'h2b;
    logic flag, r_sta, r_sto, r_ack, busy;
    logic [7:0] status, rx;
    logic scl_o, scl_oe_n, sda_o, sda_oe_n;
    logic p_scl, p_sda, p_ack;
    logic [7:0] p_errs;
    logic scl_w, sda_w;
    logic sda_q = 1'b1;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    int n_start = 0;

    // wired-and of both parties, pulled up when released
    assign scl_w = !((!scl_oe_n && !scl_o) || p_scl);
    assign sda_w = !((!sda_oe_n && !sda_o) || p_sda);

    always #5 clk = ~clk;

    ibea_core u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ctl_wr(ctl_wr),
        .i_ctl_start(ctl_sta), .i_ctl_stop(ctl_sto),
        .i_ctl_ack_en(ctl_ack), .i_ctl_int_clr(ctl_clr),
        .i_tx_byte(tx), .i_own_addr(own), .o_op_complete(flag),
        .o_status(status), .o_ctl_start(r_sta), .o_ctl_stop(r_sto),
        .o_ctl_ack_en(r_ack), .o_rx_byte(rx), .o_bus_busy(busy),
        .i_scl(scl_w), .o_scl_o(scl_o), .o_scl_oe_n(scl_oe_n),
        .i_sda(sda_w), .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n));

    ibea_bus_peer u_peer (.i_clk(clk), .i_scl(scl_w), .i_sda(sda_w),
        .o_scl_pull(p_scl), .o_sda_pull(p_sda), .o_errs(p_errs),
        .o_ack(p_ack));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic close_out();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // one control write; returns once its effect is visible
    task automatic wr(input logic sta, sto, ack, clr,
                      input logic [7:0] b);
        @(posedge clk);
        ctl_wr <= 1'b1;
        ctl_sta <= sta;
        ctl_sto <= sto;
        ctl_ack <= ack;
        ctl_clr <= clr;
        tx <= b;
        @(posedge clk);
        ctl_wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask : wr

    // wait for the flag to set, or for the bus to go free
    task automatic wait_on(input bit want_flag, input int lim);
        int t = 0;
        while ((want_flag ? flag !== 1'b1 : busy !== 1'b0) && t < lim) begin
            @(posedge clk);
            t++;
        end
        #1;
    endtask : wait_on

    // wire watch: starts and repeated starts, plus the run limit
    always @(posedge clk) begin
        if (scl_w === 1'b1 && sda_q === 1'b1 && sda_w === 1'b0) begin
            n_start <= n_start + 1;
        end
        sda_q <= sda_w;
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_mismatch++;
            close_out();
        end
    end

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_rstart();
        int lo = 0;
        int s0;
        wr(1'b1, 1'b0, 1'b0, 1'b0, 8'ha0);
        wait_on(1'b1, 12000);
        chk("rs_first", status, ST_M_DONE);
        chk("rs_start_bit", r_sta, 1'b1);
        s0 = n_start;
        // turnaround: repeated start then read address
        wr(1'b1, 1'b0, 1'b0, 1'b1, 8'ha1);
        for (int t = 0; t < 14000 && flag !== 1'b1; t++) begin
            @(posedge clk);
            if (busy !== 1'b1) lo++;
        end
        #1;
        chk("rs_status", status, ST_M_DONE);
        chk("rs_busy_low", 8'(lo), 8'h00);
        chk("rs_starts", 8'(n_start - s0), 8'h01);
        wr(1'b0, 1'b1, 1'b0, 1'b1, 8'h00);
        wait_on(1'b0, 3000);
        repeat (2) @(posedge clk);
        #1;
        chk("rs_stop_bit", r_sto, 1'b0);
    endtask : t_rstart

    task automatic t_data_loss();
        fork
            u_peer.shadow({8'ha4, 1'b1, 8'hf0, 1'b1}, 18);
            begin
                wr(1'b1, 1'b0, 1'b0, 1'b0, 8'ha4);
                wait_on(1'b1, 12000);
                chk("same_status", status, ST_M_DONE);
                wr(1'b0, 1'b0, 1'b0, 1'b1, 8'hff);
                wait_on(1'b1, 12000);
                chk("lost_status", status, ST_ARB_DATA);
                repeat (2) @(posedge clk);
                #1;
                chk("lost_lines", {scl_oe_n, sda_oe_n}, 2'b11);
            end
        join
        wait_on(1'b0, 4000);
        chk("peer_errs", p_errs, 8'h00);
        wr(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
        chk("idle_status", status, ST_NONE);
    endtask : t_data_loss

    task automatic t_addr_loss();
        for (int rw = 0; rw < 2; rw++) begin
            fork
                u_peer.shadow({own, rw[0], 1'b1, 9'h1ff}, 9);
                begin
                    wr(1'b1, 1'b0, 1'b1, 1'b0, 8'hff);
                    wait_on(1'b1, 12000);
                    chk("addr_status", status,
                        rw[0] ? ST_ARB_ST : ST_ARB_SR);
                    chk("addr_rx", rx, {own, rw[0]});
                    repeat (50) @(posedge clk);
                    chk("addr_ack", sda_oe_n, 1'b0);
                    wr(1'b0, 1'b0, 1'b1, 1'b1, 8'hff);
                end
            join
            chk("peer_ack", p_ack, 1'b0);
            wait_on(1'b0, 4000);
        end
    endtask : t_addr_loss

    task automatic t_bus_err();
        int drv = 0;
        fork
            u_peer.glitch(3);
            wr(1'b1, 1'b0, 1'b1, 1'b0, 8'hff);
        join
        wait_on(1'b1, 3000);
        chk("err_flag", flag, 1'b1);
        chk("err_status", status, ST_BUS_ERR);
        chk("err_lines", {scl_oe_n, sda_oe_n}, 2'b11);
        repeat (400) @(posedge clk);
        // recovery: stop request plus flag clear
        wr(1'b0, 1'b1, 1'b1, 1'b1, 8'hff);
        chk("rec_flag", flag, 1'b0);
        chk("rec_status", status, ST_NONE);
        chk("rec_stop_bit", r_sto, 1'b0);
        chk("rec_ack_bit", r_ack, 1'b1);
        repeat (1500) begin
            @(posedge clk);
            if (scl_oe_n !== 1'b1 || sda_oe_n !== 1'b1) drv++;
        end
        chk("rec_no_drive", 8'(drv), 8'h00);
    endtask : t_bus_err

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("rst_flag", flag, 1'b0);
        chk("rst_status", status, ST_NONE);
        chk("rst_lines", {scl_oe_n, sda_oe_n}, 2'b11);
        t_rstart();
        t_data_loss();
        t_addr_loss();
        t_bus_err();
        close_out();
    end

endmodule : i2c_bus_error_arbitration_bench
